// File: eeprom_pkg.sv
// Purpose: Shared constants and types of the two-wire serial EEPROM slave.
// Assumes: A 40 MHz system clock samples every pin.
// Notes: Times are kept in their own unit and turned into cycle counts here.
`default_nettype none

package eeprom_pkg;

    // System clock and the derived filter and write-cycle counts.
    localparam int CLK_PERIOD_NS = 25;
    localparam int NOISE_SUPPRESS_NS = 50;
    localparam int FILTER_CYCLES =
        (NOISE_SUPPRESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SELF_TIMED_WRITE_TIME_MS = 5;
    localparam int SELF_TIMED_WRITE_CYCLES =
        SELF_TIMED_WRITE_TIME_MS * 1000000 / CLK_PERIOD_NS;

    // Array organisation of the two variants.
    localparam int PAGE_BYTES = 64;
    localparam int PAGE_BITS = 6;
    localparam int ADDR_W_SMALL = 14;
    localparam int ADDR_W_LARGE = 15;
    localparam logic [3:0] DEV_TYPE_CODE = 4'hA;
    localparam logic [3:0] BITS_PER_WORD = 4'h8;

    // Register map on the APB side, byte offsets.
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] ADDR_OFFSET = 8'h08;
    localparam int CTRL_INHIBIT_BIT = 0;
    localparam logic CTRL_INHIBIT_RESET = 1'b0;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_STANDBY_BIT = 1;
    localparam int STATUS_WP_BIT = 2;

    // Protocol states of the slave.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX = 3'b001,
        ST_ACK = 3'b010,
        ST_TX = 3'b011,
        ST_MACK = 3'b100,
        ST_WRITE = 3'b101
    } state_t;

    // Meaning of the byte being received.
    typedef enum logic [1:0] {
        K_DEV = 2'b00,
        K_AHI = 2'b01,
        K_ALO = 2'b10,
        K_DATA = 2'b11
    } byte_kind_t;

    // Events seen on the filtered bus lines.
    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
    } line_ev_t;

endpackage

`default_nettype wire

// File: host.sv
// Purpose: Behavioural two-wire bus controller facing the slave.
// Assumes: sda_i is the resolved line; a pull-up holds it high.
// Notes: A quarter period is four clocks; the slave answers six clocks late.
`timescale 1ns/1ps
`default_nettype none

module host (
    input wire logic clock_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    // The link clock rests high and the line is released between frames.
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end

    // Sets both lines just after an edge, then holds them n quarters.
    task automatic step(input logic c, input logic l, input int n);
        scl_o <= c;
        sda_low_o <= l;
        repeat (4 * n) @(posedge clock_i);
    endtask

    // Start when s is high, stop when low; data is set with clock low, then flips with clock high.
    task automatic cond(input logic s);
        step(1'b0, sda_low_o, 1);
        step(1'b0, ~s, 1);
        step(1'b1, ~s, 2);
        step(1'b1, s, 2);
    endtask

    // Nine bits MSB first; the line is sampled late in each high phase.
    task automatic byte_x(input logic [8:0] d, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            step(1'b0, sda_low_o, 1);
            step(1'b0, ~d[i], 1);
            step(1'b1, ~d[i], 2);
            r[i] = sda_i;
        end
    endtask

    // Up to nine clocks until the line reads high, then a fresh start.
    task automatic recover();
        for (int i = 0; i < 9 && sda_i !== 1'b1; i++) begin
            step(1'b0, 1'b0, 2);
            step(1'b1, 1'b0, 2);
        end
        cond(1'b1);
    endtask
endmodule
`default_nettype wire

// File: mem_block.sv
// Purpose: Simple dual-port memory with registered read data.
// Assumes: One write port and one read port on the same clock.
// Notes: The array itself has no reset; only the read register is cleared.
`timescale 1ns/1ps
`default_nettype none

module mem_block #(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 15
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic we_i,
    input wire logic [ADDR_W-1:0] waddr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic [ADDR_W-1:0] raddr_i,
    output logic [DATA_W-1:0] rdata_o
);

    logic [DATA_W-1:0] mem [2**ADDR_W];

    // Storage write; a reset here would cost a clear of every word.
    always_ff @(posedge clock_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    // Read data leave through a register, one cycle after the address.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= mem[raddr_i];
        end
    end

endmodule

`default_nettype wire

// File: serial_eeprom_two_wire_slave.sv
// Purpose: Two-wire serial EEPROM slave with page buffer and APB status.
// Assumes: Bus pins are asynchronous and sampled by the 40 MHz clock.
// Notes: Bus clock and data both pass the same filter, so their order holds.
//
// Overview of operation
// - Small variant: 256 pages of 64 bytes, 14-bit word address.
// - Large variant: 512 pages of 64 bytes, 15-bit word address.
// - Data changes only while clock is low; high-clock changes are events.
// - Data falling while clock high is start; every command begins so.
// - Data rising while clock high is stop; stop after read gives standby.
// - Words are 8 bits; device pulls data low in ninth clock as acknowledge.
// - Standby at power-up and after stop once internal work completes.
// - Device address word follows start; top four bits are type pattern.
// - Three chip-select bits must equal the chip-select pins.
// - Eighth address bit: one reads, zero writes.
// - Matching address is acknowledged; mismatch stays silent, back to standby.
// - Write-protect pin high inhibits all array writes.
// - Byte write: acknowledge address and data; stop starts write cycle.
// - Self-timed write lasts up to 5 ms; inputs ignored meanwhile.
// - Page write accepts up to 63 further bytes, each acknowledged.
// - Page write increments low six address bits only, wrapping in page.
// - Address polling is acknowledged only after the write cycle ends.
// - Direction one starts current, random or sequential reads.
// - Clock and data inputs are filtered against short spikes.
// - Sample on rising clock, change output after falling clock.
// - Data line is only pulled low or released, never driven high.
// - Counter holds last address plus one; reads wrap whole array.
// - Current read sends byte at counter after the address acknowledge.
// - Each controller acknowledge sends the next byte, wrapping at the end.
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module serial_eeprom_two_wire_slave
    import eeprom_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_LARGE,
    parameter int WRITE_CYCLES = SELF_TIMED_WRITE_CYCLES
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    input wire logic wp_i,
    input wire logic chip_select_bit0_i,
    input wire logic chip_select_bit1_i,
    input wire logic chip_select_bit2_i,
    output logic standby_o,
    output logic busy_o,
    input wire logic [7:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o
);

    localparam int TW = $clog2(WRITE_CYCLES + 1);
    localparam logic [TW-1:0] WR_LAST = TW'(WRITE_CYCLES - 1);
    localparam logic [TW-1:0] COPY_END = TW'(PAGE_BYTES);
    localparam logic [3:0] FILT_CNT = 4'(FILTER_CYCLES);

    logic [5:0] meta_r;
    logic [5:0] sync_r;
    logic [1:0] line_f;
    logic scl_d_r;
    logic sda_d_r;
    line_ev_t ev;
    state_t state_r;
    byte_kind_t kind_r;
    logic [3:0] bitcnt_r;
    logic [7:0] shift_r;
    logic [7:0] ahi_r;
    logic [ADDR_W-1:0] addr_r;
    logic [PAGE_BYTES-1:0] mask_r;
    logic rw_r;
    logic mack_r;
    logic got_data_r;
    logic oe_n_r;
    logic sda_o_r;
    logic standby_r;
    logic busy_r;
    logic [TW-1:0] wtimer_r;
    logic copy_v_r;
    logic [PAGE_BITS-1:0] copy_a_r;
    logic ctrl_inhibit_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic [7:0] arr_rdata;
    logic [7:0] buf_rdata;
    logic [31:0] status_w;

    // Two flip-flops on the bus, write-protect and chip-select pins before anything reads them.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_r <= 6'h03;
            sync_r <= 6'h03;
        end else begin
            meta_r <= {chip_select_bit2_i, chip_select_bit1_i,
                       chip_select_bit0_i, wp_i, sda_i, scl_i};
            sync_r <= meta_r;
        end
    end

    wire scl_s = sync_r[0];
    wire sda_s = sync_r[1];
    wire wp_s = sync_r[2];
    wire [2:0] cs_s = sync_r[5:3];

    // A new level is taken only after it held for longer than a spike.
    for (genvar g = 0; g < 2; g++) begin : g_filt
        logic filt_r;
        logic [3:0] cnt_r;
        always_ff @(posedge clock_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                filt_r <= 1'b1;
                cnt_r <= 4'h0;
            end else if (sync_r[g] == filt_r) begin
                cnt_r <= 4'h0;
            end else if (cnt_r == FILT_CNT) begin
                filt_r <= sync_r[g];
                cnt_r <= 4'h0;
            end else begin
                cnt_r <= cnt_r + 4'h1;
            end
        end
        assign line_f[g] = filt_r;
    end

    wire scl_f = line_f[0];
    wire sda_f = line_f[1];

    // Last filtered levels, for edge and event detection.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_f;
            sda_d_r <= sda_f;
        end
    end

    // Data moving under a high clock is a start or a stop, never a bit.
    assign ev.start = scl_f & scl_d_r & sda_d_r & ~sda_f;
    assign ev.stop = scl_f & scl_d_r & ~sda_d_r & sda_f;
    assign ev.rise = scl_f & ~scl_d_r;
    assign ev.fall = ~scl_f & scl_d_r;

    // Decodes used by the protocol engine.
    wire byte_end = (state_r == ST_RX) && ev.fall &&
                    (bitcnt_r == BITS_PER_WORD);
    wire dev_match = (shift_r[7:4] == DEV_TYPE_CODE) &&
                     (shift_r[3:1] == cs_s);
    wire buf_we = byte_end && (kind_r == K_DATA);
    wire [15:0] word_addr = {ahi_r, shift_r};
    wire protect = wp_s | ctrl_inhibit_r;
    wire arr_we = copy_v_r && mask_r[copy_a_r];
    wire [ADDR_W-1:0] arr_waddr = {addr_r[ADDR_W-1:PAGE_BITS], copy_a_r};
    wire [PAGE_BITS-1:0] page_next = addr_r[PAGE_BITS-1:0] + 1'b1;

    // Protocol engine. A write cycle shuts out every bus event, so a
    // poll during it gets no acknowledge and simply finds the line high.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r <= ST_IDLE;
            kind_r <= K_DEV;
            bitcnt_r <= 4'h0;
            shift_r <= 8'h00;
            ahi_r <= 8'h00;
            addr_r <= '0;
            mask_r <= '0;
            rw_r <= 1'b0;
            mack_r <= 1'b0;
            got_data_r <= 1'b0;
            oe_n_r <= 1'b1;
            standby_r <= 1'b1;
            busy_r <= 1'b0;
            wtimer_r <= '0;
        end else if (state_r == ST_WRITE) begin
            wtimer_r <= wtimer_r + 1'b1;
            if (wtimer_r == WR_LAST) begin
                state_r <= ST_IDLE;
                standby_r <= 1'b1;
                busy_r <= 1'b0;
                mask_r <= '0;
                got_data_r <= 1'b0;
            end
        end else if (ev.start) begin
            state_r <= ST_RX;
            kind_r <= K_DEV;
            bitcnt_r <= 4'h0;
            oe_n_r <= 1'b1;
            mask_r <= '0;
            got_data_r <= 1'b0;
            standby_r <= 1'b0;
        end else if (ev.stop) begin
            oe_n_r <= 1'b1;
            wtimer_r <= '0;
            if (got_data_r && !protect) begin
                state_r <= ST_WRITE;
                busy_r <= 1'b1;
            end else begin
                state_r <= ST_IDLE;
                standby_r <= 1'b1;
                mask_r <= '0;
                got_data_r <= 1'b0;
            end
        end else begin
            case (state_r)
                ST_RX: begin
                    if (ev.rise) begin
                        shift_r <= {shift_r[6:0], sda_f};
                        bitcnt_r <= bitcnt_r + 4'h1;
                    end else if (byte_end) begin
                        if (kind_r == K_DEV && !dev_match) begin
                            state_r <= ST_IDLE;
                            standby_r <= 1'b1;
                        end else begin
                            state_r <= ST_ACK;
                            oe_n_r <= 1'b0;
                        end
                        case (kind_r)
                            K_DEV: rw_r <= shift_r[0];
                            K_AHI: ahi_r <= shift_r;
                            K_ALO: addr_r <= word_addr[ADDR_W-1:0];
                            K_DATA: begin
                                mask_r[addr_r[PAGE_BITS-1:0]] <= 1'b1;
                                got_data_r <= 1'b1;
                                addr_r[PAGE_BITS-1:0] <= page_next;
                            end
                            default: rw_r <= rw_r;
                        endcase
                    end
                end
                ST_ACK: begin
                    if (ev.fall) begin
                        bitcnt_r <= 4'h0;
                        if (kind_r == K_DEV && rw_r) begin
                            state_r <= ST_TX;
                            shift_r <= arr_rdata;
                            oe_n_r <= arr_rdata[7];
                            addr_r <= addr_r + 1'b1;
                        end else begin
                            state_r <= ST_RX;
                            oe_n_r <= 1'b1;
                            kind_r <= (kind_r == K_DEV) ? K_AHI :
                                      (kind_r == K_AHI) ? K_ALO : K_DATA;
                        end
                    end
                end
                ST_TX: begin
                    if (ev.rise) begin
                        bitcnt_r <= bitcnt_r + 4'h1;
                    end else if (ev.fall) begin
                        if (bitcnt_r == BITS_PER_WORD) begin
                            state_r <= ST_MACK;
                            oe_n_r <= 1'b1;
                        end else begin
                            shift_r <= {shift_r[6:0], 1'b0};
                            oe_n_r <= shift_r[6];
                        end
                    end
                end
                ST_MACK: begin
                    if (ev.rise) begin
                        mack_r <= ~sda_f;
                    end else if (ev.fall) begin
                        bitcnt_r <= 4'h0;
                        if (mack_r) begin
                            state_r <= ST_TX;
                            shift_r <= arr_rdata;
                            oe_n_r <= arr_rdata[7];
                            addr_r <= addr_r + 1'b1;
                        end else begin
                            state_r <= ST_IDLE;
                        end
                    end
                end
                ST_IDLE: begin
                    oe_n_r <= 1'b1;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Commit pipeline: page buffer read, then array write one cycle on.
    // Bytes are only committed after a stop, so an aborted page is lost.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            copy_v_r <= 1'b0;
            copy_a_r <= '0;
        end else begin
            copy_v_r <= (state_r == ST_WRITE) && (wtimer_r < COPY_END);
            copy_a_r <= wtimer_r[PAGE_BITS-1:0];
        end
    end

    // Pad drive value stays low; only the enable moves.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sda_o_r <= 1'b0;
        end else begin
            sda_o_r <= 1'b0;
        end
    end

    mem_block #(
        .DATA_W(8),
        .ADDR_W(ADDR_W)
    ) u_array (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .we_i(arr_we),
        .waddr_i(arr_waddr),
        .wdata_i(buf_rdata),
        .raddr_i(addr_r),
        .rdata_o(arr_rdata)
    );

    mem_block #(
        .DATA_W(8),
        .ADDR_W(PAGE_BITS)
    ) u_page_buf (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .we_i(buf_we),
        .waddr_i(addr_r[PAGE_BITS-1:0]),
        .wdata_i(shift_r),
        .raddr_i(wtimer_r[PAGE_BITS-1:0]),
        .rdata_o(buf_rdata)
    );

    // APB decode; every access takes exactly one wait-free access cycle.
    wire apb_setup = psel_i & ~penable_i;
    wire apb_wr = psel_i & penable_i & pwrite_i & pready_r;
    wire hit_ctrl = (paddr_i == CTRL_OFFSET);
    wire hit_status = (paddr_i == STATUS_OFFSET);
    wire hit_addr = (paddr_i == ADDR_OFFSET);
    wire addr_hit = hit_ctrl | hit_status | hit_addr;

    // Status word, assembled from live state.
    always_comb begin
        status_w = 32'h0000_0000;
        status_w[STATUS_BUSY_BIT] = busy_r;
        status_w[STATUS_STANDBY_BIT] = standby_r;
        status_w[STATUS_WP_BIT] = wp_s;
    end

    wire [31:0] ctrl_w = {31'h0000_0000, ctrl_inhibit_r};
    wire [31:0] addr_w = {{(32 - ADDR_W){1'b0}}, addr_r};
    wire [31:0] rd_word = hit_ctrl ? ctrl_w :
                          hit_status ? status_w :
                          hit_addr ? addr_w : 32'h0000_0000;

    // APB slave registers; unmapped addresses answer with pslverr.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            ctrl_inhibit_r <= CTRL_INHIBIT_RESET;
        end else begin
            pready_r <= apb_setup;
            pslverr_r <= apb_setup & ~addr_hit;
            prdata_r <= (apb_setup & ~pwrite_i) ? rd_word : 32'h0000_0000;
            if (apb_wr && hit_ctrl) begin
                ctrl_inhibit_r <= pwdata_i[CTRL_INHIBIT_BIT];
            end
        end
    end

    assign sda_o = sda_o_r;
    assign sda_oe_n_o = oe_n_r;
    assign standby_o = standby_r;
    assign busy_o = busy_r;
    assign prdata_o = prdata_r;
    assign pready_o = pready_r;
    assign pslverr_o = pslverr_r;

    // Checks on the protocol engine.
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    property p_out_change_scl_low;
        $changed(oe_n_r) |-> !scl_f;
    endproperty
    a_out_change_scl_low: assert property (p_out_change_scl_low)
        else $error("data output moved while clock high");

    property p_open_drain;
        !sda_oe_n_o |-> !sda_o;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("data line driven high");

    property p_ack_word;
        (byte_end && (kind_r != K_DEV || dev_match)) |=>
            (state_r == ST_ACK) && !oe_n_r;
    endproperty
    a_ack_word: assert property (p_ack_word)
        else $error("received word not acknowledged");

    property p_mismatch_silent;
        (byte_end && kind_r == K_DEV && !dev_match) |=>
            (state_r == ST_IDLE) && oe_n_r && standby_r;
    endproperty
    a_mismatch_silent: assert property (p_mismatch_silent)
        else $error("mismatched address answered");

    property p_write_silent;
        (state_r == ST_WRITE) |-> oe_n_r && busy_r && !standby_r;
    endproperty
    a_write_silent: assert property (p_write_silent)
        else $error("response during write cycle");

    property p_write_end;
        (state_r == ST_WRITE && wtimer_r == WR_LAST) |=>
            (state_r == ST_IDLE) && standby_r && !busy_r;
    endproperty
    a_write_end: assert property (p_write_end)
        else $error("write cycle did not end in standby");

    property p_page_wrap;
        buf_we |=> (addr_r[ADDR_W-1:PAGE_BITS] ==
                    $past(addr_r[ADDR_W-1:PAGE_BITS])) &&
                   (addr_r[PAGE_BITS-1:0] ==
                    $past(addr_r[PAGE_BITS-1:0]) + 1'b1);
    endproperty
    a_page_wrap: assert property (p_page_wrap)
        else $error("page address stepped wrongly");

    property p_protect;
        (ev.stop && state_r != ST_WRITE && protect) |=> state_r != ST_WRITE;
    endproperty
    a_protect: assert property (p_protect)
        else $error("write cycle under protection");

    property p_start_abort;
        (ev.start && state_r != ST_WRITE) |=>
            (state_r == ST_RX) && (kind_r == K_DEV) && (mask_r == '0);
    endproperty
    a_start_abort: assert property (p_start_abort)
        else $error("start did not restart reception");

    property p_read_step;
        (state_r == ST_ACK && ev.fall && kind_r == K_DEV && rw_r) |=>
            (state_r == ST_TX) && (addr_r == $past(addr_r) + 1'b1);
    endproperty
    a_read_step: assert property (p_read_step)
        else $error("read did not advance counter");

    property p_filter;
        $changed(scl_f) |-> ($past(scl_s) == scl_f) &&
                            ($past(scl_s, 2) == scl_f);
    endproperty
    a_filter: assert property (p_filter)
        else $error("clock spike passed the filter");

    c_byte_write: cover property ($rose(busy_r));
    c_seq_read: cover property (state_r == ST_MACK && ev.fall && mack_r);
    c_mismatch: cover property (byte_end && kind_r == K_DEV && !dev_match);
    c_page_wrap: cover property (buf_we && (&addr_r[PAGE_BITS-1:0]));

endmodule

`default_nettype wire

// File: serial_eeprom_two_wire_slave_test.sv
// Purpose: Self-checking bench of the two-wire EEPROM slave.
// Assumes: Pull-up on the line; write cycle cut to 400 clocks.
// Notes: A sparse array model holds each byte the bench wrote.
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_two_wire_slave_test;
    import eeprom_pkg::*;
    logic clk, rst_n, wp, inh, scl, sda_low, sda_o, oe_n, stby, busy, err;
    logic psel, penable, pwrite, pready, pslverr;
    logic [2:0] cs;
    logic [7:0] paddr;
    logic [8:0] r;
    logic [31:0] pwdata, prdata, got, seed;
    logic [7:0] mem [int];
    int num_errors, n_checks, ctr;
    // Open-drain wired-AND of both parties over the pull-up.
    wire logic sda = ~(sda_low | (~oe_n & ~sda_o));
    serial_eeprom_two_wire_slave #(.WRITE_CYCLES(400))
    u_serial_eeprom_two_wire_slave (.clock_i(clk), .rst_n_i(rst_n),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(oe_n),
        .wp_i(wp), .chip_select_bit0_i(cs[0]), .chip_select_bit1_i(cs[1]),
        .chip_select_bit2_i(cs[2]), .standby_o(stby), .busy_o(busy),
        .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr));
    host u_host (.clock_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
    // Clock, and a watchdog far beyond the run's length.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #1000000;
        num_errors++;
        close_out();
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; the request holds until pready is sampled high.
    task automatic apb(input logic [7:0] a, input logic w,
        input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        got = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic tx(input logic [7:0] d, input logic ack);
        u_host.byte_x({d, 1'b1}, r);
        chk({31'h0, r[0]}, {31'h0, ack});
    endtask
    task automatic seek(input logic [15:0] a);
        u_host.cond(1'b1);
        tx({DEV_TYPE_CODE, cs, 1'b0}, 1'b0);
        tx(a[15:8], 1'b0);
        tx(a[7:0], 1'b0);
        ctr = int'(a[14:0]);
    endtask
    // Page writes wrap in the low six bits; protection blocks the commit.
    task automatic wr(input logic [15:0] a, input int n, input logic [7:0] d);
        seek(a);
        for (int i = 0; i < n; i++) begin
            tx(d + 8'(i), 1'b0);
            if (wp !== 1'b1 && !inh) mem[ctr] = d + 8'(i);
            ctr = (ctr & 32'h7FC0) | ((ctr + 1) & 32'h3F);
        end
        u_host.cond(1'b0);
    endtask
    // Reads n bytes at the counter; the last one is not acknowledged.
    task automatic rd(input int n);
        u_host.cond(1'b1);
        tx({DEV_TYPE_CODE, cs, 1'b1}, 1'b0);
        for (int i = 0; i < n; i++) begin
            u_host.byte_x({8'hFF, i == n - 1}, r);
            chk({24'h0, r[8:1]}, {24'h0, mem[ctr]});
            ctr = (ctr + 1) & 32'h7FFF;
        end
        u_host.cond(1'b0);
    endtask
    // Checks whether a write cycle began, then waits out busy.
    task automatic done(input logic b);
        repeat (6) @(posedge clk);
        chk({31'h0, busy}, {31'h0, b});
        while (busy !== 1'b0) @(posedge clk);
        repeat (2) @(posedge clk);
        chk({31'h0, stby}, 32'h1);
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Reset, then the scenarios; each leaves the bus idle.
    initial begin
        {rst_n, wp, inh, psel, penable, pwrite} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        seed = xs(32'h0000002F);
        cs = seed[2:0];
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk({28'h0, sda_o, stby, busy, oe_n}, 32'h5);
        apb(STATUS_OFFSET, 1'b0, seed);
        chk(got, 32'h2);
        apb(8'h0C, 1'b1, seed);
        chk({31'h0, err}, 32'h1);
        for (int k = 1; k < 8; k++) begin
            u_host.cond(1'b1);
            tx({DEV_TYPE_CODE, cs ^ 3'(k), 1'b0}, 1'b1);
            u_host.cond(1'b0);
        end
        seed = xs(seed);
        wr(16'hFFFE, 66, seed[7:0]);
        done(1'b1);
        cs <= ~cs;
        wr(16'h8000, 1, seed[15:8]);
        u_host.cond(1'b1);
        tx({DEV_TYPE_CODE, cs, 1'b0}, 1'b1);
        u_host.cond(1'b0);
        done(1'b1);
        seek(16'h7FFD);
        rd(3);
        done(1'b0);
        rd(1);
        apb(ADDR_OFFSET, 1'b0, seed);
        chk(got, 32'h1);
        wp <= 1'b1;
        repeat (4) @(posedge clk);
        apb(STATUS_OFFSET, 1'b0, seed);
        chk(got, 32'h6);
        wr(16'h0000, 1, seed[23:16]);
        done(1'b0);
        wp <= 1'b0;
        apb(CTRL_OFFSET, 1'b1, 32'h1);
        inh = 1'b1;
        apb(CTRL_OFFSET, 1'b0, seed);
        chk(got, 32'h1);
        wr(16'h0040, 1, seed[7:0]);
        done(1'b0);
        apb(CTRL_OFFSET, 1'b1, 32'h0);
        inh = 1'b0;
        seek(16'h7FC0);
        tx(seed[31:24], 1'b0);
        u_host.recover();
        seek(16'h7FC0);
        rd(1);
        close_out();
    end
endmodule
`default_nettype wire
